//--- pkg/psa_consts.vh
`ifndef PSA_CONSTS_VH
`define PSA_CONSTS_VH

// Widths
`define PSA_VEC_W 128
`define PSA_GPR_W 64
`define PSA_OP_W 6
`define PSA_IMM_W 8
`define PSA_CNT_W 7

// Opcodes: element-wise minimum and maximum
`define PSA_OP_MIN_UW 6'h00
`define PSA_OP_MIN_UD 6'h01
`define PSA_OP_MIN_SB 6'h02
`define PSA_OP_MIN_SD 6'h03
`define PSA_OP_MAX_UW 6'h04
`define PSA_OP_MAX_UD 6'h05
`define PSA_OP_MAX_SB 6'h06
`define PSA_OP_MAX_SD 6'h07
// Opcodes: widening, sign form even, zero form odd
`define PSA_OP_SX_BW 6'h08
`define PSA_OP_ZX_BW 6'h09
`define PSA_OP_SX_BD 6'h0A
`define PSA_OP_ZX_BD 6'h0B
`define PSA_OP_SX_WD 6'h0C
`define PSA_OP_ZX_WD 6'h0D
`define PSA_OP_SX_BQ 6'h0E
`define PSA_OP_ZX_BQ 6'h0F
`define PSA_OP_SX_WQ 6'h10
`define PSA_OP_ZX_WQ 6'h11
`define PSA_OP_SX_DQ 6'h12
`define PSA_OP_ZX_DQ 6'h13
// Opcodes: other
`define PSA_OP_ABS_DIFF_SUM 6'h14
`define PSA_OP_HMIN_SEARCH 6'h15
`define PSA_OP_MASK_TEST 6'h16
`define PSA_OP_QWORD_EQ 6'h17
`define PSA_OP_QWORD_GT 6'h18
`define PSA_OP_DW_PACK_US 6'h19
`define PSA_OP_POP_COUNT 6'h1A
`define PSA_OP_INS_BYTE 6'h1B
`define PSA_OP_INS_DWORD 6'h1C
`define PSA_OP_INS_QWORD 6'h1D
`define PSA_OP_EXT_BYTE 6'h1E
`define PSA_OP_EXT_WORD 6'h1F
`define PSA_OP_EXT_DWORD 6'h20
`define PSA_OP_EXT_QWORD 6'h21
`define PSA_OP_INS_SINGLE 6'h22
`define PSA_OP_EXT_SINGLE 6'h23

// Immediate fields
`define PSA_IMM_SAD_DST_BLK 2
`define PSA_IMM_SAD_SRC_HI 1
`define PSA_IMM_SAD_SRC_LO 0
`define PSA_IMM_SRC_LANE_HI 7
`define PSA_IMM_SRC_LANE_LO 6
`define PSA_IMM_DST_LANE_HI 5
`define PSA_IMM_DST_LANE_LO 4
`define PSA_IMM_ZMASK_HI 3
`define PSA_IMM_ZMASK_LO 0

// Layout of the search result in the low dword
`define PSA_HMIN_IDX_LO 16
`define PSA_HMIN_IDX_HI 18

// Reset values
`define PSA_VEC_RST 128'h0
`define PSA_GPR_RST 64'h0

`endif

//--- core/psa_hmin_search.v
`timescale 1ns/1ps
`default_nettype none

module psa_hmin_search
(
    input wire [127:0] srcVec,
    output reg [15:0] minValue,
    output reg [2:0] minIndex
);

    integer i;
    reg [15:0] w;

    // Lowest index wins on a tie
    always @*
    begin
        minValue = srcVec[15:0];
        minIndex = 3'h0;
        w = 16'h0;
        for (i = 1; i < 8; i = i + 1)
        begin
            w = srcVec[i*16 +: 16];
            if (w < minValue)
            begin
                minValue = w;
                minIndex = i[2:0];
            end
        end
    end

endmodule

`default_nettype wire

//--- core/psa_simd_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "psa_consts.vh"

// Contract
// - Min and max on four element types
// - Sign-widen low narrow elements, six pairs
// - Zero-widen low narrow elements, six pairs
// - Eight 4-byte absolute-difference sums to words
// - Find smallest of eight unsigned words
// - Pack minimum and position into low dword
// - Test AND with mask, set zero flag
// - AND with inverted mask sets carry flag
// - Per-qword equality of two operands
// - Per-qword signed greater-than
// - Dword to word, unsigned saturation
// - Count set bits into general register
// - Insert byte, dword, qword into lane
// - Extract byte, word, dword, qword lane
// - Single insert with lane select, zero mask
// - Single extract of lane to register
module psa_simd_alu
(
    input wire mclk,
    input wire rst_n,
    input wire opValid,
    input wire [`PSA_OP_W-1:0] opCode,
    input wire [`PSA_VEC_W-1:0] vecDst,
    input wire [`PSA_VEC_W-1:0] vecSrc,
    input wire [`PSA_GPR_W-1:0] gprSrc,
    input wire srcIsMem,
    input wire [`PSA_IMM_W-1:0] immByte,
    output reg resValid_r,
    output reg vecWrite_r,
    output reg gprWrite_r,
    output reg flagWrite_r,
    output reg [`PSA_VEC_W-1:0] vecResult_r,
    output reg [`PSA_GPR_W-1:0] gprResult_r,
    output reg zeroFlag_r,
    output reg carryFlag_r
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Element-wise min or max, element width w bits
    function [127:0] laneMinMax;
        input [127:0] a;
        input [127:0] b;
        input integer w;
        input sgn;
        input isMax;
        integer i;
        reg [127:0] sa;
        reg [127:0] sb;
        reg [32:0] ea;
        reg [32:0] eb;
        reg [31:0] msk;
        reg aLess;
        reg [127:0] pick;
        begin
            laneMinMax = 128'h0;
            msk = 32'hFFFFFFFF >> (32 - w);
            for (i = 0; i < 128 / w; i = i + 1)
            begin
                sa = a >> (i * w);
                sb = b >> (i * w);
                ea = {1'b0, sa[31:0] & msk};
                eb = {1'b0, sb[31:0] & msk};
                if (sgn)
                begin
                    ea = ea ^ (33'h1 << (w - 1));
                    eb = eb ^ (33'h1 << (w - 1));
                end
                aLess = ea < eb;
                pick = (aLess ^ isMax) ? a : b;
                pick = (pick >> (i * w)) & {96'h0, msk};
                laneMinMax = laneMinMax | (pick << (i * w));
            end
        end
    endfunction

    // Widen the low elements of s from sw bits to dw bits
    function [127:0] widen;
        input [63:0] s;
        input integer sw;
        input integer dw;
        input sx;
        integer b;
        integer ln;
        integer p;
        begin
            widen = 128'h0;
            for (b = 0; b < 128; b = b + 1)
            begin
                ln = b / dw;
                p = b % dw;
                if (p < sw)
                    widen[b] = s[ln*sw + p];
                else
                    widen[b] = sx & s[ln*sw + sw - 1];
            end
        end
    endfunction

    function [7:0] absDiff8;
        input [7:0] x;
        input [7:0] y;
        begin
            absDiff8 = (x > y) ? x - y : y - x;
        end
    endfunction

    function [15:0] satWord;
        input [31:0] d;
        begin
            if (d[31])
                satWord = 16'h0000;
            else if (d[30:16] != 15'h0)
                satWord = 16'hFFFF;
            else
                satWord = d[15:0];
        end
    endfunction

    function [`PSA_CNT_W-1:0] bitCount;
        input [63:0] v;
        integer i;
        begin
            bitCount = 7'h0;
            for (i = 0; i < 64; i = i + 1)
                bitCount = bitCount + {6'h0, v[i]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Horizontal search

    wire [15:0] hminValue;
    wire [2:0] hminIndex;

    psa_hmin_search uHmin
    (
        .srcVec(vecSrc),
        .minValue(hminValue),
        .minIndex(hminIndex)
    );

    ////////////////////////////////////////////////////////////////////////
    // Absolute-difference sums

    reg [127:0] sadVec;
    reg [15:0] sadSum;
    reg [7:0] dstByte;
    reg [7:0] srcByte;
    integer si;
    integer sj;
    integer dOff;
    integer sOff;

    always @*
    begin
        sadVec = 128'h0;
        sadSum = 16'h0;
        dstByte = 8'h0;
        srcByte = 8'h0;
        dOff = immByte[`PSA_IMM_SAD_DST_BLK] ? 4 : 0;
        sOff = immByte[`PSA_IMM_SAD_SRC_HI:`PSA_IMM_SAD_SRC_LO] * 4;
        for (si = 0; si < 8; si = si + 1)
        begin
            sadSum = 16'h0;
            for (sj = 0; sj < 4; sj = sj + 1)
            begin
                dstByte = vecDst[(dOff + si + sj)*8 +: 8];
                srcByte = vecSrc[(sOff + sj)*8 +: 8];
                sadSum = sadSum + {8'h0, absDiff8(dstByte, srcByte)};
            end
            sadVec[si*16 +: 16] = sadSum;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result selection

    reg [127:0] vecNxt;
    reg [63:0] gprNxt;
    reg vecWrNxt;
    reg gprWrNxt;
    reg flagWrNxt;
    reg zeroNxt;
    reg carryNxt;
    reg [31:0] singleVal;
    reg [1:0] dstLane;
    integer k;

    always @*
    begin
        vecNxt = vecDst;
        gprNxt = 64'h0;
        vecWrNxt = 1'b0;
        gprWrNxt = 1'b0;
        flagWrNxt = 1'b0;
        zeroNxt = zeroFlag_r;
        carryNxt = carryFlag_r;
        singleVal = 32'h0;
        dstLane = immByte[`PSA_IMM_DST_LANE_HI:`PSA_IMM_DST_LANE_LO];
        case (opCode)
            `PSA_OP_MIN_UW, `PSA_OP_MAX_UW:
            begin
                vecNxt = laneMinMax(vecDst, vecSrc, 16, 1'b0, opCode[2]);
                vecWrNxt = 1'b1;
            end
            `PSA_OP_MIN_UD, `PSA_OP_MAX_UD:
            begin
                vecNxt = laneMinMax(vecDst, vecSrc, 32, 1'b0, opCode[2]);
                vecWrNxt = 1'b1;
            end
            `PSA_OP_MIN_SB, `PSA_OP_MAX_SB:
            begin
                vecNxt = laneMinMax(vecDst, vecSrc, 8, 1'b1, opCode[2]);
                vecWrNxt = 1'b1;
            end
            `PSA_OP_MIN_SD, `PSA_OP_MAX_SD:
            begin
                vecNxt = laneMinMax(vecDst, vecSrc, 32, 1'b1, opCode[2]);
                vecWrNxt = 1'b1;
            end
            `PSA_OP_SX_BW, `PSA_OP_ZX_BW:
            begin
                vecNxt = widen(vecSrc[63:0], 8, 16, ~opCode[0]);
                vecWrNxt = 1'b1;
            end
            `PSA_OP_SX_BD, `PSA_OP_ZX_BD:
            begin
                vecNxt = widen(vecSrc[63:0], 8, 32, ~opCode[0]);
                vecWrNxt = 1'b1;
            end
            `PSA_OP_SX_WD, `PSA_OP_ZX_WD:
            begin
                vecNxt = widen(vecSrc[63:0], 16, 32, ~opCode[0]);
                vecWrNxt = 1'b1;
            end
            `PSA_OP_SX_BQ, `PSA_OP_ZX_BQ:
            begin
                vecNxt = widen(vecSrc[63:0], 8, 64, ~opCode[0]);
                vecWrNxt = 1'b1;
            end
            `PSA_OP_SX_WQ, `PSA_OP_ZX_WQ:
            begin
                vecNxt = widen(vecSrc[63:0], 16, 64, ~opCode[0]);
                vecWrNxt = 1'b1;
            end
            `PSA_OP_SX_DQ, `PSA_OP_ZX_DQ:
            begin
                vecNxt = widen(vecSrc[63:0], 32, 64, ~opCode[0]);
                vecWrNxt = 1'b1;
            end
            `PSA_OP_ABS_DIFF_SUM:
            begin
                vecNxt = sadVec;
                vecWrNxt = 1'b1;
            end
            `PSA_OP_HMIN_SEARCH:
            begin
                vecNxt = 128'h0;
                vecNxt[15:0] = hminValue;
                vecNxt[`PSA_HMIN_IDX_HI:`PSA_HMIN_IDX_LO] = hminIndex;
                vecWrNxt = 1'b1;
            end
            `PSA_OP_MASK_TEST:
            begin
                zeroNxt = ~|(vecDst & vecSrc);
                carryNxt = ~|(vecDst & ~vecSrc);
                flagWrNxt = 1'b1;
            end
            `PSA_OP_QWORD_EQ:
            begin
                for (k = 0; k < 2; k = k + 1)
                    vecNxt[k*64 +: 64] = {64{vecDst[k*64 +: 64] == vecSrc[k*64 +: 64]}};
                vecWrNxt = 1'b1;
            end
            `PSA_OP_QWORD_GT:
            begin
                for (k = 0; k < 2; k = k + 1)
                    vecNxt[k*64 +: 64] = {64{$signed(vecDst[k*64 +: 64])
                        > $signed(vecSrc[k*64 +: 64])}};
                vecWrNxt = 1'b1;
            end
            `PSA_OP_DW_PACK_US:
            begin
                for (k = 0; k < 4; k = k + 1)
                begin
                    vecNxt[k*16 +: 16] = satWord(vecDst[k*32 +: 32]);
                    vecNxt[64 + k*16 +: 16] = satWord(vecSrc[k*32 +: 32]);
                end
                vecWrNxt = 1'b1;
            end
            `PSA_OP_POP_COUNT:
            begin
                gprNxt = {57'h0, bitCount(gprSrc)};
                gprWrNxt = 1'b1;
            end
            `PSA_OP_INS_BYTE:
            begin
                vecNxt[immByte[3:0]*8 +: 8] = gprSrc[7:0];
                vecWrNxt = 1'b1;
            end
            `PSA_OP_INS_DWORD:
            begin
                vecNxt[immByte[1:0]*32 +: 32] = gprSrc[31:0];
                vecWrNxt = 1'b1;
            end
            `PSA_OP_INS_QWORD:
            begin
                vecNxt[immByte[0]*64 +: 64] = gprSrc;
                vecWrNxt = 1'b1;
            end
            `PSA_OP_EXT_BYTE:
            begin
                gprNxt = {56'h0, vecSrc[immByte[3:0]*8 +: 8]};
                gprWrNxt = 1'b1;
            end
            `PSA_OP_EXT_WORD:
            begin
                gprNxt = {48'h0, vecSrc[immByte[2:0]*16 +: 16]};
                gprWrNxt = 1'b1;
            end
            `PSA_OP_EXT_DWORD:
            begin
                gprNxt = {32'h0, vecSrc[immByte[1:0]*32 +: 32]};
                gprWrNxt = 1'b1;
            end
            `PSA_OP_EXT_QWORD:
            begin
                gprNxt = vecSrc[immByte[0]*64 +: 64];
                gprWrNxt = 1'b1;
            end
            `PSA_OP_INS_SINGLE:
            begin
                // Memory form ignores the source lane field
                if (srcIsMem)
                    singleVal = gprSrc[31:0];
                else
                    singleVal = vecSrc[immByte[`PSA_IMM_SRC_LANE_HI:`PSA_IMM_SRC_LANE_LO]*32 +: 32];
                vecNxt[dstLane*32 +: 32] = singleVal;
                for (k = 0; k < 4; k = k + 1)
                    if (immByte[`PSA_IMM_ZMASK_LO + k])
                        vecNxt[k*32 +: 32] = 32'h0;
                vecWrNxt = 1'b1;
            end
            `PSA_OP_EXT_SINGLE:
            begin
                gprNxt = {32'h0, vecSrc[immByte[1:0]*32 +: 32]};
                gprWrNxt = 1'b1;
            end
            default:
            begin
                vecNxt = vecDst;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Result registers, one cycle after the request

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            resValid_r <= 1'b0;
            vecWrite_r <= 1'b0;
            gprWrite_r <= 1'b0;
            flagWrite_r <= 1'b0;
            vecResult_r <= `PSA_VEC_RST;
            gprResult_r <= `PSA_GPR_RST;
            zeroFlag_r <= 1'b0;
            carryFlag_r <= 1'b0;
        end
        else
        begin
            resValid_r <= opValid;
            vecWrite_r <= opValid & vecWrNxt;
            gprWrite_r <= opValid & gprWrNxt;
            flagWrite_r <= opValid & flagWrNxt;
            if (opValid)
            begin
                vecResult_r <= vecNxt;
                gprResult_r <= gprNxt;
                zeroFlag_r <= zeroNxt;
                carryFlag_r <= carryNxt;
            end
        end
    end

endmodule

`default_nettype wire

//--- tb/psa_simd_alu_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "psa_consts.vh"

module psa_simd_alu_asserts
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic opValid,
    input wire logic [5:0] opCode,
    input wire logic [127:0] vecDst,
    input wire logic [127:0] vecSrc,
    input wire logic [63:0] gprSrc,
    input wire logic resValid_r,
    input wire logic vecWrite_r,
    input wire logic gprWrite_r,
    input wire logic flagWrite_r,
    input wire logic [127:0] vecResult_r,
    input wire logic [63:0] gprResult_r,
    input wire logic zeroFlag_r,
    input wire logic carryFlag_r
);
    wire logic [63:0] dLo = vecDst[63:0];
    wire logic [63:0] sLo = vecSrc[63:0];
    wire logic [63:0] dHi = vecDst[127:64];
    wire logic [63:0] sHi = vecSrc[127:64];
    wire logic anyWr = vecWrite_r | gprWrite_r | flagWrite_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    chk_answer_next: assert property (opValid |=> resValid_r)
        else $error("no answer one cycle after request");
    chk_no_spurious: assert property (!opValid |=> !resValid_r && !anyWr)
        else $error("answer without request");
    chk_strobe_onehot: assert property (anyWr |-> resValid_r && $onehot0({vecWrite_r, gprWrite_r, flagWrite_r}))
        else $error("write strobes inconsistent");
    chk_test_strobe: assert property (opValid && opCode == `PSA_OP_MASK_TEST |=> flagWrite_r && !vecWrite_r)
        else $error("mask test strobes wrong");
    chk_zero_flag: assert property (opValid && opCode == `PSA_OP_MASK_TEST
        |=> zeroFlag_r == (($past(vecDst) & $past(vecSrc)) == 128'h0))
        else $error("zero flag wrong");
    chk_carry_flag: assert property (opValid && opCode == `PSA_OP_MASK_TEST
        |=> carryFlag_r == (($past(vecDst) & ~$past(vecSrc)) == 128'h0))
        else $error("carry flag wrong");
    chk_flags_hold: assert property (!flagWrite_r && $past(rst_n) |-> $stable({zeroFlag_r, carryFlag_r}))
        else $error("flags changed without mask test");
    chk_pop_count: assert property (opValid && opCode == `PSA_OP_POP_COUNT
        |=> gprWrite_r && gprResult_r == $countones($past(gprSrc)))
        else $error("population count wrong");
    chk_qword_equal: assert property (opValid && opCode == `PSA_OP_QWORD_EQ
        |=> vecResult_r[63:0] == {64{$past(dLo) == $past(sLo)}})
        else $error("qword equality lane wrong");
    chk_qword_greater: assert property (opValid && opCode == `PSA_OP_QWORD_GT
        |=> vecResult_r[127:64] == {64{$signed($past(dHi)) > $signed($past(sHi))}})
        else $error("qword greater lane wrong");
    chk_hmin_upper: assert property (opValid && opCode == `PSA_OP_HMIN_SEARCH
        |=> vecWrite_r && vecResult_r[127:19] == 109'h0)
        else $error("search result upper bits not zero");
    chk_result_hold: assert property (!resValid_r && $past(rst_n) |-> $stable({vecResult_r, gprResult_r}))
        else $error("result changed without request");
endmodule

bind psa_simd_alu psa_simd_alu_asserts u_chk (.mclk, .rst_n, .opValid, .opCode, .vecDst, .vecSrc,
    .gprSrc, .resValid_r, .vecWrite_r, .gprWrite_r, .flagWrite_r, .vecResult_r, .gprResult_r,
    .zeroFlag_r, .carryFlag_r);
`default_nettype wire

//--- tb/psa_decode_model.sv
`timescale 1ns/1ps
`default_nettype none

module psa_decode_model
(
    input wire logic mclk,
    input wire logic issue,
    input wire logic [5:0] opSel,
    output var logic opValid,
    output var logic [5:0] opCode,
    output var logic [127:0] vecDst,
    output var logic [127:0] vecSrc,
    output var logic [63:0] gprSrc,
    output var logic srcIsMem,
    output var logic [7:0] immByte
);
    reg [127:0] d;
    reg [127:0] s;

    initial
    begin
        opValid = 1'b0;
        opCode = 6'h3F;
        vecDst = 128'h0;
        vecSrc = 128'h0;
        gprSrc = 64'h0;
        srcIsMem = 1'b0;
        immByte = 8'h00;
    end

    // Operands change only at the falling edge; scrambled when idle
    always @(negedge mclk)
    begin
        opValid <= issue;
        opCode <= issue ? opSel : ~opCode;
        d = {$urandom, $urandom, $urandom, $urandom};
        s = {$urandom, $urandom, $urandom, $urandom};
        case ($urandom % 4)
            0: s = ~d;
            1: s = d;
            2:
            begin
                d = d & {4{32'h8001FFFF}};
                s = s & {4{32'h8001FFFF}};
            end
            default: s = s;
        endcase
        vecDst <= issue ? d : ~vecDst;
        vecSrc <= issue ? s : ~vecSrc;
        gprSrc <= issue ? {$urandom, $urandom} : ~gprSrc;
        srcIsMem <= issue ? $urandom % 2 : ~srcIsMem;
        immByte <= issue ? $urandom % 256 : ~immByte;
    end
endmodule
`default_nettype wire

//--- tb/packed_integer_simd_alu_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "psa_consts.vh"

module packed_integer_simd_alu_tb_top;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg issue = 1'b0;
    reg [5:0] opSel = 6'h00;
    reg pend = 1'b0;
    reg inRst = 1'b1;
    wire opValid, srcIsMem, resValid_r, vecWrite_r, gprWrite_r, flagWrite_r, zeroFlag_r, carryFlag_r;
    wire [5:0] opCode;
    wire [7:0] immByte;
    wire [127:0] vecDst, vecSrc, vecResult_r;
    wire [63:0] gprSrc, gprResult_r;
    reg [127:0] expVec;
    reg [63:0] expGpr;
    reg [2:0] expStb;
    reg expZ = 1'b0;
    reg expC = 1'b0;
    integer failures = 0;
    integer n_tests = 0;
    integer cycles = 0;
    integer k;

    always #50 mclk = ~mclk;

    psa_decode_model u_dec (.mclk, .issue, .opSel, .opValid, .opCode, .vecDst, .vecSrc, .gprSrc,
        .srcIsMem, .immByte);
    psa_simd_alu dut (.mclk, .rst_n, .opValid, .opCode, .vecDst, .vecSrc, .gprSrc, .srcIsMem,
        .immByte, .resValid_r, .vecWrite_r, .gprWrite_r, .flagWrite_r, .vecResult_r, .gprResult_r,
        .zeroFlag_r, .carryFlag_r);

    ////////////////////////////////////////////////////////////////////////////
    task automatic predict(input [5:0] op, input [127:0] d, input [127:0] s, input [63:0] g,
        input m, input [7:0] im);
        integer i, j, w, sw, dw;
        reg [127:0] r, a, b, msk, n;
        begin
            r = d;
            expGpr = 64'h0;
            expStb = 3'b100;
            if (op < 6'h08)
            begin
                w = op[1:0] == 2'h0 ? 16 : op[1:0] == 2'h2 ? 8 : 32;
                msk = (128'h1 << w) - 1;
                n = op[1] ? 128'h1 << (w - 1) : 128'h0;
                for (i = 0; i < 128 / w; i = i + 1)
                begin
                    a = (d >> (i * w)) & msk;
                    b = (s >> (i * w)) & msk;
                    a = (((a ^ n) < (b ^ n)) ^ op[2]) ? a : b;
                    r = (r & ~(msk << (i * w))) | (a << (i * w));
                end
            end
            else if (op < 6'h14)
            begin
                j = (op - 8) / 2;
                sw = (j == 2 || j == 4) ? 16 : j == 5 ? 32 : 8;
                dw = j == 0 ? 16 : j < 3 ? 32 : 64;
                msk = (128'h1 << sw) - 1;
                r = 128'h0;
                for (i = 0; i < 128 / dw; i = i + 1)
                begin
                    a = (s >> (i * sw)) & msk;
                    if (!op[0] && a[sw - 1])
                        a = a | ~msk;
                    a = a & ((128'h1 << dw) - 1);
                    r = r | (a << (i * dw));
                end
            end
            else if (op == `PSA_OP_ABS_DIFF_SUM || op == `PSA_OP_DW_PACK_US)
            begin
                r = 128'h0;
                for (i = 0; i < 8; i = i + 1)
                begin
                    n = 128'h0;
                    for (j = 0; j < 4; j = j + 1)
                    begin
                        a = (d >> (8 * (4 * im[2] + i + j))) & 128'hFF;
                        b = (s >> (8 * (4 * im[1:0] + j))) & 128'hFF;
                        n = n + (a > b ? a - b : b - a);
                    end
                    if (op == `PSA_OP_DW_PACK_US)
                    begin
                        n = ((i < 4 ? d : s) >> (32 * (i % 4))) & 128'hFFFFFFFF;
                        n = n[31] ? 128'h0 : n > 128'hFFFF ? 128'hFFFF : n;
                    end
                    r = r | (n << (16 * i));
                end
            end
            else if (op == `PSA_OP_HMIN_SEARCH)
            begin
                r = s & 128'hFFFF;
                for (i = 1; i < 8; i = i + 1)
                begin
                    a = (s >> (16 * i)) & 128'hFFFF;
                    if (a < r[15:0])
                        r = a | (i << 16);
                end
            end
            else if (op == `PSA_OP_MASK_TEST)
            begin
                expStb = 3'b001;
                expZ = (d & s) == 128'h0;
                expC = (d & ~s) == 128'h0;
            end
            else if (op == `PSA_OP_QWORD_EQ || op == `PSA_OP_QWORD_GT)
                r = {{64{op == `PSA_OP_QWORD_EQ ? d[127:64] == s[127:64] :
                    $signed(d[127:64]) > $signed(s[127:64])}},
                    {64{op == `PSA_OP_QWORD_EQ ? d[63:0] == s[63:0] :
                    $signed(d[63:0]) > $signed(s[63:0])}}};
            else if (op == `PSA_OP_POP_COUNT)
            begin
                expStb = 3'b010;
                expGpr = $countones(g);
            end
            else if (op >= `PSA_OP_INS_BYTE && op <= `PSA_OP_INS_QWORD)
            begin
                w = op == `PSA_OP_INS_BYTE ? 8 : op == `PSA_OP_INS_DWORD ? 32 : 64;
                msk = (128'h1 << w) - 1;
                j = im & (128 / w - 1);
                r = (d & ~(msk << (j * w))) | ((g & msk) << (j * w));
            end
            else if (op >= `PSA_OP_EXT_BYTE && op <= `PSA_OP_EXT_SINGLE && op != `PSA_OP_INS_SINGLE)
            begin
                w = op == `PSA_OP_EXT_SINGLE ? 32 : 8 << (op - `PSA_OP_EXT_BYTE);
                j = im & (128 / w - 1);
                a = (s >> (j * w)) & ((128'h1 << w) - 1);
                expStb = 3'b010;
                expGpr = a[63:0];
            end
            else if (op == `PSA_OP_INS_SINGLE)
            begin
                a = m ? {96'h0, g[31:0]} : (s >> (32 * im[7:6])) & 128'hFFFFFFFF;
                r = (d & ~(128'hFFFFFFFF << (32 * im[5:4]))) | (a << (32 * im[5:4]));
                for (i = 0; i < 4; i = i + 1)
                    if (im[i])
                        r = r & ~(128'hFFFFFFFF << (32 * i));
            end
            else
                expStb = 3'b000;
            expVec = r;
        end
    endtask

    task check(input [199:0] seen, input [199:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp)
            begin
                failures = failures + 1;
                $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task step(input [5:0] op, input on);
        begin
            @(posedge mclk);
            issue <= on;
            opSel <= op;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk)
    begin
        pend <= rst_n && opValid;
        inRst <= !rst_n;
        cycles <= cycles + 1;
        if (!rst_n)
            {expZ, expC} = 2'b00;
        else if (opValid)
            predict(opCode, vecDst, vecSrc, gprSrc, srcIsMem, immByte);
        if (cycles == 5000)
        begin
            failures = failures + 1;
            give_verdict;
        end
    end

    always @(negedge mclk)
        if (inRst)
            check({resValid_r, vecWrite_r, gprWrite_r, flagWrite_r, zeroFlag_r, carryFlag_r,
                vecResult_r, gprResult_r}, 200'h0);
        else
        begin
            check({resValid_r, vecWrite_r, gprWrite_r, flagWrite_r}, {pend, pend ? expStb : 3'b0});
            check({zeroFlag_r, carryFlag_r}, {expZ, expC});
            if (pend)
                check(vecResult_r, expVec);
            if (pend)
                check(gprResult_r, expGpr);
        end

    initial
    begin
        void'($urandom(49458));
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) step(6'h00, 1'b0);
        for (k = 0; k < 36; k = k + 1)
            repeat (12) step(k[5:0], 1'b1);
        repeat (300) step(6'($urandom % 40), $urandom % 4 != 0);
        step(6'h00, 1'b0);
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        repeat (20) step(`PSA_OP_MASK_TEST, 1'b1);
        repeat (4) step(6'h00, 1'b0);
        give_verdict;
    end
endmodule
`default_nettype wire
